/* hw/adcc_clock_divider.v */
// Converter clock tick generator dividing the system clock
`include "adcc_defines.vh"

module adcc_clock_divider (
    input wire core_clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire clear_in,
    input wire [2:0] div_sel_in,
    output reg tick_out
);

    reg [5:0] count;
    reg [5:0] limit;

    // ****************************************
    // Divide ratio
    // ****************************************
    // Undefined setting falls back to the slowest ratio so a conversion never stalls
    always @* begin
        if (div_sel_in == `ADCC_DIV_UNDEF) begin
            limit = 6'h3F;
        end else begin
            limit = (6'h01 << div_sel_in) - 6'h01;
        end
    end

    // ****************************************
    // Counter
    // ****************************************
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            count <= 6'h00;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            if (clear_in || count >= limit) begin
                count <= 6'h00;
            end else begin
                count <= count + 6'h01;
            end
            tick_out <= !clear_in && (count >= limit);
        end
    end

endmodule

/* hw/adcc_top.v */
// Converter control top with AXI4-Lite registers and pin steering
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`include "adcc_defines.vh"

module adcc_top #(
    parameter PINS = 12
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [7:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output reg s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output reg s_axi_wready_out,
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [7:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output reg s_axi_arready_out,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    input wire [11:0] conv_data_in,
    input wire [PINS-1:0] port_direction_in,
    input wire [PINS-1:0] pull_high_en_in,
    output reg [PINS-1:0] pin_direction_out,
    output reg [PINS-1:0] pull_high_out,
    output reg [PINS-1:0] analog_pin_sel_out,
    output reg [PINS-1:0] digital_func_en_out,
    output reg ref_pin_sel_out,
    output reg ref_pin_other_func_en_out,
    output reg converter_power_out,
    output reg converter_reset_out,
    output reg converter_sample_out,
    output reg [4:0] channel_out,
    output reg conversion_done_out,
    output reg irq_out
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_HOLD = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;

    reg [7:0] converter_control_low;
    reg [7:0] converter_control_high;
    reg [7:0] analog_pin_enable_low;
    reg [3:0] analog_pin_enable_high;
    reg conversion_pending_flag;
    reg irq_flag;
    reg converter_interrupt_enable;
    reg global_interrupt_enable;
    reg [11:0] result;
    reg [2:0] state;
    reg [4:0] tick_count;
    reg div_clear;
    reg [11:0] data_meta;
    reg [11:0] data_sync;
    reg aw_full;
    reg [7:0] aw_addr;
    reg w_full;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg next_aw_full;
    reg next_w_full;
    reg next_bvalid;
    reg next_rvalid;
    reg [31:0] rd_mux;
    reg rd_hit;
    wire tick;
    wire start_bit;
    wire power_down;
    wire do_write;
    wire wr_hit;
    wire wr_lane;
    wire int_clear;
    wire conv_done;
    wire conv_tick;
    wire [PINS-1:0] analog_pin_enables;

    assign start_bit = converter_control_low[`ADCC_CL_START];
    assign power_down = converter_control_low[`ADCC_CL_POWER_DOWN];
    assign analog_pin_enables = {analog_pin_enable_high, analog_pin_enable_low};
    assign do_write = aw_full && w_full && !s_axi_bvalid_out;
    assign wr_lane = w_strb[0];
    assign wr_hit = (aw_addr == `ADCC_OFF_CTRL_LOW) || (aw_addr == `ADCC_OFF_CTRL_HIGH) ||
        (aw_addr == `ADCC_OFF_PIN_EN_LOW) || (aw_addr == `ADCC_OFF_PIN_EN_HIGH) ||
        (aw_addr == `ADCC_OFF_INT_CTRL) || (aw_addr == `ADCC_OFF_RESULT_LOW) ||
        (aw_addr == `ADCC_OFF_RESULT_HIGH);
    assign int_clear = do_write && wr_lane && (aw_addr == `ADCC_OFF_INT_CTRL) &&
        !w_data[`ADCC_IC_FLAG];
    // A tick already launched when the divider restarts is stale and must not count
    assign conv_tick = tick && !div_clear && !start_bit && !power_down;
    // Last of sixteen ticks, aborted by a new start or power-down
    assign conv_done = (state == ST_CONV) && conv_tick &&
        (tick_count == `ADCC_CONV_TICKS - 5'h01);

    adcc_clock_divider u_div (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .clear_in(div_clear),
        .div_sel_in(converter_control_high[2:0]),
        .tick_out(tick)
    );

    // ****************************************
    // Bus handshake
    // ****************************************
    always @* begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_bvalid = s_axi_bvalid_out;
        next_rvalid = s_axi_rvalid_out;
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            next_aw_full = 1'b1;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            next_w_full = 1'b1;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
        end
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && s_axi_arready_out) begin
            next_rvalid = 1'b1;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr_in)
            `ADCC_OFF_CTRL_LOW: begin
                rd_mux[7:0] = {converter_control_low[7], conversion_pending_flag,
                    converter_control_low[5:0]};
            end
            `ADCC_OFF_CTRL_HIGH: rd_mux[7:0] = converter_control_high;
            `ADCC_OFF_PIN_EN_LOW: rd_mux[7:0] = analog_pin_enable_low;
            `ADCC_OFF_PIN_EN_HIGH: rd_mux[3:0] = analog_pin_enable_high;
            `ADCC_OFF_INT_CTRL: begin
                rd_mux[2:0] = {global_interrupt_enable, converter_interrupt_enable, irq_flag};
            end
            `ADCC_OFF_RESULT_LOW: rd_mux[7:0] = result[7:0];
            `ADCC_OFF_RESULT_HIGH: rd_mux[3:0] = result[11:8];
            default: rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // Bus slave and software registers
    // ****************************************
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `ADCC_RESP_OKAY;
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rresp_out <= `ADCC_RESP_OKAY;
            s_axi_rdata_out <= 32'h00000000;
            converter_control_low <= `ADCC_RST_CTRL_LOW;
            converter_control_high <= `ADCC_RST_CTRL_HIGH;
            analog_pin_enable_low <= `ADCC_RST_PIN_EN_LOW;
            analog_pin_enable_high <= `ADCC_RST_PIN_EN_HIGH;
            converter_interrupt_enable <= 1'b0;
            global_interrupt_enable <= 1'b0;
        end else if (ce_in) begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_bvalid_out <= next_bvalid;
            s_axi_rvalid_out <= next_rvalid;
            s_axi_awready_out <= !next_aw_full && !next_bvalid;
            s_axi_wready_out <= !next_w_full && !next_bvalid;
            s_axi_arready_out <= !next_rvalid;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_rdata_out <= rd_mux;
                s_axi_rresp_out <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end
            if (do_write) begin
                s_axi_bresp_out <= wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
            end
            // Only byte lane 0 carries register bits; result registers ignore writes
            if (do_write && wr_lane) begin
                case (aw_addr)
                    `ADCC_OFF_CTRL_LOW: converter_control_low <= w_data[7:0];
                    `ADCC_OFF_CTRL_HIGH: converter_control_high <= w_data[7:0];
                    `ADCC_OFF_PIN_EN_LOW: analog_pin_enable_low <= w_data[7:0];
                    `ADCC_OFF_PIN_EN_HIGH: analog_pin_enable_high <= w_data[3:0];
                    `ADCC_OFF_INT_CTRL: begin
                        converter_interrupt_enable <= w_data[`ADCC_IC_CONV_EN];
                        global_interrupt_enable <= w_data[`ADCC_IC_GLOBAL_EN];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            tick_count <= 5'h00;
            div_clear <= 1'b0;
            conversion_pending_flag <= 1'b0;
            irq_flag <= 1'b0;
            result <= 12'h000;
            data_meta <= 12'h000;
            data_sync <= 12'h000;
        end else if (ce_in) begin
            // Converter output is asynchronous; software must not read mid-update
            data_meta <= conv_data_in;
            data_sync <= data_meta;
            div_clear <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start_bit) begin
                        state <= ST_HOLD;
                        conversion_pending_flag <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    conversion_pending_flag <= 1'b1;
                    if (!start_bit) begin
                        if (power_down) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_CONV;
                            tick_count <= 5'h00;
                            div_clear <= 1'b1;
                        end
                    end
                end
                ST_CONV: begin
                    if (start_bit) begin
                        state <= ST_HOLD;
                    end else if (power_down) begin
                        // Power loss abandons the cycle; pending stays high, no result
                        state <= ST_IDLE;
                    end else if (conv_done) begin
                        state <= ST_IDLE;
                        conversion_pending_flag <= 1'b0;
                        result <= data_sync;
                    end else if (conv_tick) begin
                        tick_count <= tick_count + 5'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Set wins over a software clear in the same cycle
            if (conv_done) begin
                irq_flag <= 1'b1;
            end else if (int_clear) begin
                irq_flag <= 1'b0;
            end
        end
    end

    // ****************************************
    // Converter and reference outputs
    // ****************************************
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            converter_power_out <= 1'b0;
            converter_reset_out <= 1'b0;
            converter_sample_out <= 1'b0;
            channel_out <= 5'h00;
            ref_pin_sel_out <= 1'b0;
            ref_pin_other_func_en_out <= 1'b1;
            conversion_done_out <= 1'b0;
            irq_out <= 1'b0;
        end else if (ce_in) begin
            converter_power_out <= !power_down;
            converter_reset_out <= start_bit;
            converter_sample_out <= (state == ST_CONV) && conv_tick;
            channel_out <= {converter_control_high[`ADCC_CH_CHAN_HI],
                converter_control_low[3:0]};
            ref_pin_sel_out <= converter_control_high[`ADCC_CH_REF_SEL];
            ref_pin_other_func_en_out <= !converter_control_high[`ADCC_CH_REF_SEL];
            conversion_done_out <= conv_done;
            // Both enables needed, mirroring the processor's interrupt gating
            irq_out <= irq_flag && converter_interrupt_enable &&
                global_interrupt_enable;
        end
    end

    // ****************************************
    // Pin steering
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < PINS; i = i + 1) begin : g_pin
            always @(posedge core_clk_in) begin
                if (rst_in) begin
                    pin_direction_out[i] <= 1'b1;
                    pull_high_out[i] <= 1'b0;
                    analog_pin_sel_out[i] <= 1'b0;
                    digital_func_en_out[i] <= 1'b1;
                end else if (ce_in) begin
                    analog_pin_sel_out[i] <= analog_pin_enables[i];
                    digital_func_en_out[i] <= !analog_pin_enables[i];
                    pull_high_out[i] <= pull_high_en_in[i] && !analog_pin_enables[i];
                    pin_direction_out[i] <= analog_pin_enables[i] | port_direction_in[i];
                end
            end
        end
    endgenerate

endmodule

/* inc/adcc_defines.vh */
// Constants for the converter control block
// Summary of operation
// - Start pulse high then low begins conversion
// - Start held high resets converter, pending set
// - Hardware clears pending flag at conversion end
// - End sets request flag, interrupt when enabled
// - Three-bit select divides system clock by powers
// - Power-down bit high switches converter off
// - Reference select routes external reference pin
// - Pin enable makes pin converter input
// - Analog pin disconnects its pull-high resistor
// - Analog pin enable overrides port direction
// - Five-bit split channel select picks input
// - Conversion takes sixteen converter clock periods
// - Twelve-bit result, full scale all ones
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define ADCC_OFF_CTRL_LOW 8'h00
`define ADCC_OFF_CTRL_HIGH 8'h04
`define ADCC_OFF_PIN_EN_LOW 8'h08
`define ADCC_OFF_PIN_EN_HIGH 8'h0C
`define ADCC_OFF_INT_CTRL 8'h10
`define ADCC_OFF_RESULT_LOW 8'h14
`define ADCC_OFF_RESULT_HIGH 8'h18

// ****************************************
// Field positions
// ****************************************
`define ADCC_CL_START 7
`define ADCC_CL_PENDING 6
`define ADCC_CL_POWER_DOWN 5
`define ADCC_CH_REF_SEL 3
`define ADCC_CH_CHAN_HI 4
`define ADCC_IC_FLAG 0
`define ADCC_IC_CONV_EN 1
`define ADCC_IC_GLOBAL_EN 2

// ****************************************
// Reset values
// ****************************************
`define ADCC_RST_CTRL_LOW 8'h20
`define ADCC_RST_CTRL_HIGH 8'h00
`define ADCC_RST_PIN_EN_LOW 8'hFF
`define ADCC_RST_PIN_EN_HIGH 4'hF

// ****************************************
// Timing and bus responses
// ****************************************
`define ADCC_CONV_TICKS 5'h10
`define ADCC_DIV_UNDEF 3'h7
`define ADCC_RESP_OKAY 2'h0
`define ADCC_RESP_SLVERR 2'h2

`endif

/* verif/adcc_conv_model.sv */
// Behavioural model of the analog converter that feeds result words
module adcc_conv_model (
    input wire logic core_clk_in,
    input wire logic power_in,
    input wire logic [11:0] code_in,
    output logic [11:0] conv_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial conv_data_out = 12'h5A5;
    // Unpowered output is not valid: toggle it so a stale word is never mistaken
    always @(posedge core_clk_in) begin
        if (power_in) begin
            conv_data_out <= code_in;
        end else begin
            conv_data_out <= ~conv_data_out;
        end
    end
endmodule

/* verif/adcc_top_bench.sv */
// Self-checking bench for the converter control block
`include "adcc_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t value mismatch got %h expected %h", $time, g, e); end end
module adcc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [11:0] port_direction_in = 12'h000, pull_high_en_in = 12'h000, code = 12'h000;
    wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    wire s_axi_rvalid_out, ref_pin_sel_out, ref_pin_other_func_en_out, converter_power_out;
    wire converter_reset_out, converter_sample_out, conversion_done_out, irq_out;
    wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    wire [11:0] pin_direction_out, pull_high_out, analog_pin_sel_out, digital_func_en_out;
    wire [11:0] conv_data_in;
    wire [4:0] channel_out;
    int mismatches = 0;
    int num_checks = 0;
    int n, cnt, last, bad, per;
    logic [1:0] rsp;
    logic [31:0] ic;
    always #5 core_clk_in = ~core_clk_in;
    adcc_top #(.PINS(12)) DUT (
        .core_clk_in, .rst_in, .ce_in(1'b1), .s_axi_awaddr_in, .s_axi_awvalid_in,
        .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in,
        .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
        .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .conv_data_in,
        .port_direction_in, .pull_high_en_in, .pin_direction_out, .pull_high_out,
        .analog_pin_sel_out, .digital_func_en_out, .ref_pin_sel_out,
        .ref_pin_other_func_en_out, .converter_power_out, .converter_reset_out,
        .converter_sample_out, .channel_out, .conversion_done_out, .irq_out
    );
    adcc_conv_model u_conv (
        .core_clk_in, .power_in(converter_power_out), .code_in(code),
        .conv_data_out(conv_data_in)
    );
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit b = 0;
        int k = 0;
        @(posedge core_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        while (!b && k < 200) begin
            @(posedge core_clk_in);
            k++;
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            if (s_axi_bvalid_out) begin
                b = 1;
                r = s_axi_bresp_out;
                s_axi_bready_in <= 1'b0;
            end
        end
        `CHK(b, 1'b1)
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        bit t = 0;
        int k = 0;
        @(posedge core_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        while (!t && k < 200) begin
            @(posedge core_clk_in);
            k++;
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            if (s_axi_rvalid_out) begin
                t = 1;
                `CHK(s_axi_rdata_out, e)
                `CHK(s_axi_rresp_out, er)
                s_axi_rready_in <= 1'b0;
            end
        end
        `CHK(t, 1'b1)
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (16) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        `CHK(converter_power_out, 1'b0)
        `CHK(analog_pin_sel_out, 12'hFFF)
        rchk(`ADCC_OFF_CTRL_LOW, 32'h20, `ADCC_RESP_OKAY);
        rchk(`ADCC_OFF_PIN_EN_HIGH, 32'h0F, `ADCC_RESP_OKAY);
        rchk(8'h1C, 32'h0, `ADCC_RESP_SLVERR);
        wr(8'h1C, 32'hFF, rsp);
        `CHK(rsp, `ADCC_RESP_SLVERR)
        port_direction_in <= 12'h0A0;
        pull_high_en_in <= 12'hFFF;
        wr(`ADCC_OFF_PIN_EN_LOW, 32'h0F, rsp);
        wr(`ADCC_OFF_PIN_EN_HIGH, 32'h0, rsp);
        repeat (2) @(posedge core_clk_in);
        `CHK(digital_func_en_out, 12'hFF0)
        `CHK(pin_direction_out, 12'h0AF)
        `CHK(pull_high_out, 12'hFF0)
        wr(`ADCC_OFF_CTRL_LOW, 32'h03, rsp);
        repeat (20) @(posedge core_clk_in);
        for (int d = 0; d < 8; d++) begin
            code <= (d == 0) ? 12'hFFF : {9'h0B4, d[2:0]};
            per = (d == 7) ? 64 : (1 << d);
            ic = (d == 2) ? 32'h6 : ((d == 3) ? 32'h4 : 32'h2);
            wr(`ADCC_OFF_CTRL_HIGH, {29'h3, d[2:0]}, rsp);
            wr(`ADCC_OFF_INT_CTRL, ic, rsp);
            wr(`ADCC_OFF_CTRL_LOW, 32'h83, rsp);
            repeat (2) @(posedge core_clk_in);
            `CHK(converter_reset_out, 1'b1)
            `CHK(channel_out, 5'h13)
            `CHK({ref_pin_sel_out, ref_pin_other_func_en_out}, 2'b10)
            rchk(`ADCC_OFF_CTRL_LOW, 32'hC3, `ADCC_RESP_OKAY);
            wr(`ADCC_OFF_CTRL_LOW, 32'h03, rsp);
            n = 0;
            cnt = 0;
            bad = 0;
            while (!conversion_done_out && n < 3000) begin
                @(posedge core_clk_in);
                n++;
                if (converter_sample_out) begin
                    if (cnt > 0 && n - last != per) bad++;
                    cnt++;
                    last = n;
                end
            end
            `CHK(cnt, 16)
            `CHK(bad, 0)
            repeat (2) @(posedge core_clk_in);
            `CHK(irq_out, 1'(d == 2))
            rchk(`ADCC_OFF_INT_CTRL, ic | 32'h1, `ADCC_RESP_OKAY);
            rchk(`ADCC_OFF_CTRL_LOW, 32'h03, `ADCC_RESP_OKAY);
            rchk(`ADCC_OFF_RESULT_LOW, {24'h0, code[7:0]}, `ADCC_RESP_OKAY);
            rchk(`ADCC_OFF_RESULT_HIGH, {28'h0, code[11:8]}, `ADCC_RESP_OKAY);
            wr(`ADCC_OFF_INT_CTRL, 32'h6, rsp);
            repeat (2) @(posedge core_clk_in);
            `CHK(irq_out, 1'b0)
        end
        // Power-down in mid-conversion: no result, pending left high
        code <= 12'h123;
        wr(`ADCC_OFF_CTRL_HIGH, 32'h16, rsp);
        wr(`ADCC_OFF_CTRL_LOW, 32'h83, rsp);
        wr(`ADCC_OFF_CTRL_LOW, 32'h03, rsp);
        repeat (100) @(posedge core_clk_in);
        wr(`ADCC_OFF_CTRL_LOW, 32'h23, rsp);
        n = 0;
        repeat (1500) begin
            @(posedge core_clk_in);
            if (conversion_done_out) n++;
        end
        `CHK(n, 0)
        `CHK(converter_power_out, 1'b0)
        `CHK({ref_pin_sel_out, ref_pin_other_func_en_out}, 2'b01)
        rchk(`ADCC_OFF_CTRL_LOW, 32'h63, `ADCC_RESP_OKAY);
        rchk(`ADCC_OFF_RESULT_LOW, 32'hA7, `ADCC_RESP_OKAY);
        report_and_stop;
    end
    initial begin
        #300000;
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop;
    end
endmodule

/* verif/adcc_top_sva.sv */
// Assertion checker for the converter control top
module adcc_top_sva #(
    parameter PINS = 12
) (
    input logic core_clk_in,
    input logic rst_in,
    input logic s_axi_arvalid_in,
    input logic s_axi_arready_out,
    input logic [31:0] s_axi_rdata_out,
    input logic s_axi_rvalid_out,
    input logic s_axi_rready_in,
    input logic [PINS-1:0] port_direction_in,
    input logic [PINS-1:0] pull_high_en_in,
    input logic [PINS-1:0] pin_direction_out,
    input logic [PINS-1:0] pull_high_out,
    input logic [PINS-1:0] analog_pin_sel_out,
    input logic [PINS-1:0] digital_func_en_out,
    input logic converter_power_out,
    input logic converter_reset_out,
    input logic converter_sample_out,
    input logic conversion_done_out,
    input logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Ticks seen in the running conversion
    // ****************************************
    logic [4:0] ticks;
    always_ff @(posedge core_clk_in) begin
        if (rst_in || converter_reset_out || conversion_done_out) begin
            ticks <= 5'h00;
        end else if (converter_sample_out) begin
            ticks <= ticks + 5'h01;
        end
    end
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // ****************************************
    // Properties
    // ****************************************
    a_pin_excl: assert property (analog_pin_sel_out == ~digital_func_en_out)
        else $error("analog and digital pin functions overlap");
    a_pull_drop: assert property (!$past(rst_in) |->
        pull_high_out == ($past(pull_high_en_in) & ~analog_pin_sel_out))
        else $error("pull-high left on an analog pin");
    a_dir_override: assert property (!$past(rst_in) |->
        pin_direction_out == ($past(port_direction_in) | analog_pin_sel_out))
        else $error("analog pin not forced to input");
    a_hold_quiet: assert property (converter_reset_out |->
        !converter_sample_out && !conversion_done_out)
        else $error("converter active while held in reset");
    // Two clocks of slack: sample and done already fall on the same edge as power
    a_power_quiet: assert property (!converter_power_out &&
        !$past(converter_power_out, 2) |-> !converter_sample_out && !conversion_done_out)
        else $error("converter active while powered down");
    a_start_runs: assert property ($fell(converter_reset_out) && converter_power_out
        |-> ##[1:100] converter_sample_out)
        else $error("no tick after start pulse");
    a_sixteen_ticks: assert property (conversion_done_out |->
        ticks + {4'h0, converter_sample_out} == 5'h10)
        else $error("conversion did not take sixteen ticks");
    a_done_pulse: assert property (conversion_done_out |=> !conversion_done_out)
        else $error("end of conversion longer than one clock");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
        s_axi_rvalid_out)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped before taken");
    c_done: cover property (conversion_done_out);
    c_irq: cover property (irq_out);
    c_rstall: cover property (s_axi_rvalid_out && !s_axi_rready_in);
endmodule
bind adcc_top adcc_top_sva #(.PINS(PINS)) u_sva (
    .core_clk_in, .rst_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .port_direction_in, .pull_high_en_in,
    .pin_direction_out, .pull_high_out, .analog_pin_sel_out, .digital_func_en_out,
    .converter_power_out, .converter_reset_out, .converter_sample_out,
    .conversion_done_out, .irq_out
);
